// File: core_event_model.sv
`default_nettype none
module core_event_model (
  // Core clock, requested events and the levels the block sees.
  input  wire logic                              aclk,
  input  wire perf_counter_two_pkg::core_event_t next_ev,
  output var  perf_counter_two_pkg::core_event_t core_events
);
  timeunit 1ns;
  timeprecision 1ns;
  // The sources are core flops, so each level reaches the block one edge late.
  initial core_events = '0;
  always @(posedge aclk) begin
    core_events <= next_ev;
  end
endmodule : core_event_model
`default_nettype wire

// File: event_counter_accum.sv
`default_nettype none
module event_counter_accum #(
  parameter int WIDTH     = 32,
  parameter int INC_WIDTH = 3
) (
  // Clock and reset.
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // Software load, per byte lane.
  input  wire logic                 load_en,
  input  wire logic [WIDTH-1:0]     load_data,
  input  wire logic [WIDTH/8-1:0]   load_strb,
  // Increment for this cycle.
  input  wire logic [INC_WIDTH-1:0] inc,
  // Counter value.
  output logic      [WIDTH-1:0]     count_q
);

  logic [WIDTH-1:0] count_d;
  logic [WIDTH-1:0] sum;

  // A zero increment keeps the value, so a held counter sees no change.
  assign sum = count_q + WIDTH'(inc);

  always_comb begin
    count_d = sum;
    if (load_en) begin
      for (int i = 0; i < WIDTH / 8; i++) begin
        if (load_strb[i]) begin
          count_d[i*8 +: 8] = load_data[i*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= perf_counter_two_pkg::COUNTER_RESET;
    end else begin
      count_q <= count_d;
    end
  end

endmodule : event_counter_accum
`default_nettype wire

// File: pc2_props.sv
`default_nettype none
module pc2_props #(
  parameter int COUNTER_WIDTH = 32
) (
  // Watched ports of the counter block.
  input wire logic                     aclk,
  input wire logic                     aresetn,
  input wire logic                     s_axi_awvalid,
  input wire logic                     s_axi_awready,
  input wire logic                     s_axi_wvalid,
  input wire logic                     s_axi_wready,
  input wire logic                     s_axi_bvalid,
  input wire logic                     s_axi_bready,
  input wire logic [1:0]               s_axi_bresp,
  input wire logic                     s_axi_arvalid,
  input wire logic                     s_axi_arready,
  input wire logic                     s_axi_rvalid,
  input wire logic                     s_axi_rready,
  input wire logic [31:0]              s_axi_rdata,
  input wire logic [COUNTER_WIDTH-1:0] second_event_counter
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  r_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");
  w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer not held");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  r_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  b_cause_a: assert property ($rose(s_axi_bvalid) |->
    $past(s_axi_awvalid && s_axi_awready || s_axi_wvalid && s_axi_wready, 2))
    else $error("write response without request");
  cnt_step_a: assert property (
    !s_axi_awvalid && !s_axi_wvalid ##1 !s_axi_awvalid && !s_axi_wvalid
    |=> second_event_counter - $past(second_event_counter) <= 4)
    else $error("counter step too large");
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property (s_axi_arvalid && s_axi_arready);
  cover property (second_event_counter - $past(second_event_counter) == 4);
endmodule : pc2_props
bind perf_counter_two_event_select pc2_props #(.COUNTER_WIDTH(COUNTER_WIDTH)) u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .second_event_counter(second_event_counter));
`default_nettype wire

// File: perf_counter_two_event_select.sv
`default_nettype none
module perf_counter_two_event_select #(
  parameter int COUNTER_WIDTH = 32
) (
  // Clock and reset.
  input  wire logic                               aclk,
  input  wire logic                               aresetn,
  // AXI4-Lite write address channel.
  input  wire logic                               s_axi_awvalid,
  output logic                                    s_axi_awready,
  input  wire logic [3:0]                         s_axi_awaddr,
  input  wire logic [2:0]                         s_axi_awprot,
  // AXI4-Lite write data channel.
  input  wire logic                               s_axi_wvalid,
  output logic                                    s_axi_wready,
  input  wire logic [31:0]                        s_axi_wdata,
  input  wire logic [3:0]                         s_axi_wstrb,
  // AXI4-Lite write response channel.
  output logic                                    s_axi_bvalid,
  input  wire logic                               s_axi_bready,
  output logic      [1:0]                         s_axi_bresp,
  // AXI4-Lite read address channel.
  input  wire logic                               s_axi_arvalid,
  output logic                                    s_axi_arready,
  input  wire logic [3:0]                         s_axi_araddr,
  input  wire logic [2:0]                         s_axi_arprot,
  // AXI4-Lite read data channel.
  output logic                                    s_axi_rvalid,
  input  wire logic                               s_axi_rready,
  output logic      [31:0]                        s_axi_rdata,
  output logic      [1:0]                         s_axi_rresp,
  // Core event sources.
  input  wire perf_counter_two_pkg::core_event_t  core_events,
  // Counter value for the rest of the monitor.
  output logic      [COUNTER_WIDTH-1:0]           second_event_counter
);

  localparam int IW = perf_counter_two_pkg::INC_WIDTH;
  localparam int SW = perf_counter_two_pkg::SELECT_WIDTH;
  localparam int TW = perf_counter_two_pkg::THRESHOLD_WIDTH;

  // One occurrence as an increment.
  function automatic logic [IW-1:0] one(input logic hit);
    return {{(IW-1){1'b0}}, hit};
  endfunction : one

  // A two-bit occurrence count as an increment.
  function automatic logic [IW-1:0] many(input logic [1:0] cnt);
    return {{(IW-2){1'b0}}, cnt};
  endfunction : many

  // Byte-lane merge of a write into a register.
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // Write channel state.
  logic                     aw_held_q;
  logic [3:0]               aw_addr_q;
  logic                     w_held_q;
  logic [31:0]              w_data_q;
  logic [3:0]               w_strb_q;
  logic                     bvalid_q;
  logic [1:0]               bresp_q;
  logic                     wr_fire;
  // Read channel state.
  logic                     rvalid_q;
  logic [31:0]              rdata_q;
  logic [1:0]               rresp_q;
  logic                     rd_fire;
  // Registers.
  logic [SW-1:0]            counter_two_event_select_q;
  logic [TW-1:0]            threshold_q;
  logic                     priv_q;
  logic                     priv_seen_q;
  logic [IW-1:0]            inc;
  logic                     load_counter;
  logic [COUNTER_WIDTH-1:0] count;
  logic [31:0]              count_word;
  logic [31:0]              select_word;
  logic [31:0]              threshold_word;
  logic [31:0]              status_word;

  // Write address and data are taken in either order, one write at a time.
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign wr_fire       = aw_held_q && w_held_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= perf_counter_two_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      if (aw_addr_q == perf_counter_two_pkg::SELECT_OFFSET ||
          aw_addr_q == perf_counter_two_pkg::THRESHOLD_OFFSET ||
          aw_addr_q == perf_counter_two_pkg::COUNTER_OFFSET) begin
        bresp_q <= perf_counter_two_pkg::RESP_OKAY;
      end else begin
        bresp_q <= perf_counter_two_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Control registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter_two_event_select_q <= perf_counter_two_pkg::SELECT_RESET;
    end else if (wr_fire && aw_addr_q == perf_counter_two_pkg::SELECT_OFFSET) begin
      counter_two_event_select_q <= SW'(merge(select_word, w_data_q, w_strb_q));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      threshold_q <= perf_counter_two_pkg::THRESHOLD_RESET;
    end else if (wr_fire && aw_addr_q == perf_counter_two_pkg::THRESHOLD_OFFSET) begin
      threshold_q <= TW'(merge(threshold_word, w_data_q, w_strb_q));
    end
  end

  assign load_counter = wr_fire && aw_addr_q == perf_counter_two_pkg::COUNTER_OFFSET;

  // Read channel answers one cycle after the address is taken.
  assign s_axi_arready = !rvalid_q;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  assign select_word    = {{(32-SW){1'b0}}, counter_two_event_select_q};
  assign threshold_word = {{(32-TW){1'b0}}, threshold_q};
  assign count_word     = 32'(count);
  // Status shows the increment applied this cycle and the queue depth.
  assign status_word    = {16'h0000, 2'b00, core_events.cq_valid_entries,
                           5'b00000, inc};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= perf_counter_two_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rresp_q  <= perf_counter_two_pkg::RESP_OKAY;
      case (s_axi_araddr)
        perf_counter_two_pkg::SELECT_OFFSET: begin
          rdata_q <= select_word;
        end
        perf_counter_two_pkg::THRESHOLD_OFFSET: begin
          rdata_q <= threshold_word;
        end
        perf_counter_two_pkg::COUNTER_OFFSET: begin
          rdata_q <= count_word;
        end
        perf_counter_two_pkg::STATUS_OFFSET: begin
          rdata_q <= status_word;
        end
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= perf_counter_two_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // The first cycle after reset only captures the privilege level.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      priv_q      <= 1'b0;
      priv_seen_q <= 1'b0;
    end else begin
      priv_q      <= core_events.user_privilege_bit;
      priv_seen_q <= 1'b1;
    end
  end

  // Event selection.
  always_comb begin
    perf_counter_two_pkg::core_event_t e;
    e   = core_events;
    inc = '0;
    case (perf_counter_two_pkg::sel_code_t'(counter_two_event_select_q))
      perf_counter_two_pkg::SEL_NOTHING: begin
        inc = '0;
      end
      perf_counter_two_pkg::SEL_LSU_DONE: begin
        inc = many(e.lsu_done_cnt);
      end
      perf_counter_two_pkg::SEL_LOAD_DONE: begin
        inc = one(e.load_done && !e.load_excluded_op &&
                  !(e.load_string_indexed && e.fixed_point_exception_len == 7'h00));
      end
      perf_counter_two_pkg::SEL_STRING_STORE: begin
        inc = one(e.string_store_done);
      end
      perf_counter_two_pkg::SEL_TLB_INVAL: begin
        inc = one(e.tlb_inval_done);
      end
      perf_counter_two_pkg::SEL_LOAD_RESERVE: begin
        inc = one(e.load_reserve_done);
      end
      perf_counter_two_pkg::SEL_MOVE_FROM_SPR: begin
        inc = one(e.move_from_spr_done && !e.move_from_spr_vector_status);
      end
      perf_counter_two_pkg::SEL_REFETCH: begin
        inc = one(e.isync_done || e.system_call_op_done || e.rfi_done ||
                  e.summary_overflow_change || e.interrupt_taken ||
                  ((e.single_step_trace_bit || e.branch_trace_bit) &&
                   e.branch_speculative) ||
                  e.float_target_unchanged ||
                  (e.block_alloc_done && e.block_alloc_wt_or_ci));
      end
      perf_counter_two_pkg::SEL_CQ_THRESHOLD: begin
        inc = one(e.cq_valid_entries >= threshold_q);
      end
      perf_counter_two_pkg::SEL_ONE_COMPLETE: begin
        inc = one(e.complete_cnt == 2'd1);
      end
      perf_counter_two_pkg::SEL_TWO_DISPATCH: begin
        inc = one(e.dispatch_cnt == 2'd2);
      end
      perf_counter_two_pkg::SEL_ITRANS_MISS: begin
        inc = one(e.itrans_miss && !e.itrans_miss_speculative);
      end
      perf_counter_two_pkg::SEL_IMISS_CYCLES: begin
        inc = one(e.icache_miss_pending);
      end
      perf_counter_two_pkg::SEL_DLOAD_MISS: begin
        inc = one(e.dload_miss && !e.dload_miss_table_search &&
                  !e.dload_miss_touch);
      end
      perf_counter_two_pkg::SEL_DTOUCH_MISS: begin
        inc = one(e.dtouch_miss_reload);
      end
      perf_counter_two_pkg::SEL_DSTORE_MISS: begin
        inc = one(e.dstore_miss);
      end
      perf_counter_two_pkg::SEL_DTOUCH_CYCLES: begin
        inc = one(e.dtouch_miss_pending);
      end
      perf_counter_two_pkg::SEL_DCACHE_BUSY: begin
        inc = one(e.dcache_busy && !e.dcache_snoop);
      end
      perf_counter_two_pkg::SEL_STREAM1_FETCH: begin
        inc = one(e.first_stream_engine_fetch);
      end
      perf_counter_two_pkg::SEL_TOUCH_CANCEL: begin
        inc = (e.touch_cancel_cnt > 3'd4) ? 3'd4 : e.touch_cancel_cnt;
      end
      perf_counter_two_pkg::SEL_TOUCH_RESUME: begin
        inc = one(e.touch_resume_context);
      end
      perf_counter_two_pkg::SEL_TOUCH_MISS: begin
        inc = one(e.touch_fetch_miss);
      end
      perf_counter_two_pkg::SEL_TOUCH_FETCH: begin
        inc = one(e.touch_fetch);
      end
      perf_counter_two_pkg::SEL_TLB_SNOOP: begin
        inc = one(e.tlb_inval_snoop);
      end
      perf_counter_two_pkg::SEL_IRELOAD: begin
        inc = one(e.ireload && !e.ireload_inhibited);
      end
      perf_counter_two_pkg::SEL_DRELOAD: begin
        inc = one(e.dreload && !e.dreload_inhibited && !e.dreload_disabled &&
                  !e.dreload_all_locked);
      end
      perf_counter_two_pkg::SEL_CASTOUT: begin
        inc = one(e.castout);
      end
      perf_counter_two_pkg::SEL_STORE_MERGE: begin
        inc = one(e.store_merge);
      end
      perf_counter_two_pkg::SEL_FULL_MERGE: begin
        inc = one(e.store_merge_full_line);
      end
      perf_counter_two_pkg::SEL_DATA_BREAK: begin
        inc = one(e.data_break_int);
      end
      perf_counter_two_pkg::SEL_NOT_TAKEN: begin
        inc = many(e.not_taken_cnt);
      end
      perf_counter_two_pkg::SEL_BUF1_CORRECT: begin
        inc = one(e.buf1_correct);
      end
      perf_counter_two_pkg::SEL_BUF2_ACTIVE: begin
        inc = one(e.buf2_active);
      end
      perf_counter_two_pkg::SEL_LINK_STALL: begin
        inc = one(e.link_reg_unresolved &&
                  (!e.link_stack_enabled || e.link_stack_empty));
      end
      perf_counter_two_pkg::SEL_TARGET_MISS: begin
        inc = one(e.target_cache_miss);
      end
      perf_counter_two_pkg::SEL_LINK_CORRECT: begin
        inc = one(e.link_stack_correct);
      end
      perf_counter_two_pkg::SEL_FLOAT_STALL: begin
        inc = one(e.float_issue_stall);
      end
      perf_counter_two_pkg::SEL_PRIV_SWITCH: begin
        inc = one(priv_seen_q && (priv_q != e.user_privilege_bit));
      end
      perf_counter_two_pkg::SEL_FLOAT_STORE: begin
        inc = one(e.float_store_single_done && !e.float_store_misaligned);
      end
      default: begin
        inc = '0;
      end
    endcase
  end

  // A software write to the counter takes precedence over counting in its strobed byte lanes; the other lanes keep counting.
  event_counter_accum #(
    .WIDTH     (COUNTER_WIDTH),
    .INC_WIDTH (IW)
  ) u_accum (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .load_en   (load_counter),
    .load_data (COUNTER_WIDTH'(w_data_q)),
    .load_strb (w_strb_q[COUNTER_WIDTH/8-1:0]),
    .inc       (inc),
    .count_q   (count)
  );

  assign second_event_counter = count;

endmodule : perf_counter_two_event_select
`default_nettype wire

// File: perf_counter_two_pkg.sv
`default_nettype none
package perf_counter_two_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [3:0]  SELECT_OFFSET     = 4'h0;
  localparam logic [3:0]  THRESHOLD_OFFSET  = 4'h4;
  localparam logic [3:0]  COUNTER_OFFSET    = 4'h8;
  localparam logic [3:0]  STATUS_OFFSET     = 4'hc;

  // Field widths and reset values.
  localparam int          SELECT_WIDTH      = 7;
  localparam int          THRESHOLD_WIDTH   = 6;
  localparam int          INC_WIDTH         = 3;
  localparam logic [6:0]  SELECT_RESET      = 7'h00;
  localparam logic [5:0]  THRESHOLD_RESET   = 6'h00;
  localparam logic [31:0] COUNTER_RESET     = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  // Event-select encodings handled by this block.
  typedef enum logic [6:0] {
    SEL_NOTHING       = 7'b000_0000,
    SEL_LSU_DONE      = 7'b001_1001,
    SEL_LOAD_DONE     = 7'b001_1010,
    SEL_STRING_STORE  = 7'b001_1011,
    SEL_TLB_INVAL     = 7'b001_1100,
    SEL_LOAD_RESERVE  = 7'b001_1101,
    SEL_MOVE_FROM_SPR = 7'b001_1110,
    SEL_REFETCH       = 7'b001_1111,
    SEL_CQ_THRESHOLD  = 7'b010_0000,
    SEL_ONE_COMPLETE  = 7'b010_0001,
    SEL_TWO_DISPATCH  = 7'b010_0010,
    SEL_ITRANS_MISS   = 7'b010_0011,
    SEL_IMISS_CYCLES  = 7'b010_0100,
    SEL_DLOAD_MISS    = 7'b010_0101,
    SEL_DTOUCH_MISS   = 7'b010_0110,
    SEL_DSTORE_MISS   = 7'b010_0111,
    SEL_DTOUCH_CYCLES = 7'b010_1000,
    SEL_DCACHE_BUSY   = 7'b010_1001,
    SEL_STREAM1_FETCH = 7'b010_1010,
    SEL_TOUCH_CANCEL  = 7'b010_1011,
    SEL_TOUCH_RESUME  = 7'b010_1100,
    SEL_TOUCH_MISS    = 7'b010_1101,
    SEL_TOUCH_FETCH   = 7'b010_1110,
    SEL_TLB_SNOOP     = 7'b010_1111,
    SEL_IRELOAD       = 7'b011_0000,
    SEL_DRELOAD       = 7'b011_0001,
    SEL_CASTOUT       = 7'b011_0010,
    SEL_STORE_MERGE   = 7'b011_0011,
    SEL_FULL_MERGE    = 7'b011_0100,
    SEL_DATA_BREAK    = 7'b011_0101,
    SEL_NOT_TAKEN     = 7'b011_0110,
    SEL_BUF1_CORRECT  = 7'b011_0111,
    SEL_BUF2_ACTIVE   = 7'b011_1000,
    SEL_LINK_STALL    = 7'b011_1001,
    SEL_TARGET_MISS   = 7'b011_1010,
    SEL_LINK_CORRECT  = 7'b011_1011,
    SEL_FLOAT_STALL   = 7'b011_1100,
    SEL_PRIV_SWITCH   = 7'b011_1101,
    SEL_FLOAT_STORE   = 7'b011_1110
  } sel_code_t;

  // Event sources from the core, all on the core clock.
  typedef struct packed {
    logic [1:0] lsu_done_cnt;
    logic       load_done;
    logic       load_excluded_op;
    logic       load_string_indexed;
    logic [6:0] fixed_point_exception_len;
    logic       string_store_done;
    logic       tlb_inval_done;
    logic       load_reserve_done;
    logic       move_from_spr_done;
    logic       move_from_spr_vector_status;
    logic       isync_done;
    logic       system_call_op_done;
    logic       rfi_done;
    logic       summary_overflow_change;
    logic       interrupt_taken;
    logic       branch_speculative;
    logic       single_step_trace_bit;
    logic       branch_trace_bit;
    logic       float_target_unchanged;
    logic       block_alloc_done;
    logic       block_alloc_wt_or_ci;
    logic [5:0] cq_valid_entries;
    logic [1:0] complete_cnt;
    logic [1:0] dispatch_cnt;
    logic       itrans_miss;
    logic       itrans_miss_speculative;
    logic       icache_miss_pending;
    logic       dload_miss;
    logic       dload_miss_table_search;
    logic       dload_miss_touch;
    logic       dtouch_miss_reload;
    logic       dstore_miss;
    logic       dtouch_miss_pending;
    logic       dcache_busy;
    logic       dcache_snoop;
    logic       first_stream_engine_fetch;
    logic [2:0] touch_cancel_cnt;
    logic       touch_resume_context;
    logic       touch_fetch_miss;
    logic       touch_fetch;
    logic       tlb_inval_snoop;
    logic       ireload;
    logic       ireload_inhibited;
    logic       dreload;
    logic       dreload_inhibited;
    logic       dreload_disabled;
    logic       dreload_all_locked;
    logic       castout;
    logic       store_merge;
    logic       store_merge_full_line;
    logic       data_break_int;
    logic [1:0] not_taken_cnt;
    logic       buf1_correct;
    logic       buf2_active;
    logic       link_reg_unresolved;
    logic       link_stack_enabled;
    logic       link_stack_empty;
    logic       target_cache_miss;
    logic       link_stack_correct;
    logic       float_issue_stall;
    logic       float_store_single_done;
    logic       float_store_misaligned;
    logic       user_privilege_bit;
  } core_event_t;

endpackage : perf_counter_two_pkg
`default_nettype wire

// File: tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [1:0] OK = perf_counter_two_pkg::RESP_OKAY;
  logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0;
  logic awr, wrd, bv, arr, rv;
  logic [1:0] br, rr;
  logic [3:0] aa = 4'h0, ra = 4'h0, ws = 4'h0;
  logic [31:0] wd = 32'h0, rd, cnt;
  perf_counter_two_pkg::core_event_t ev = '0, ev_in;
  int error_cnt = 0, compares = 0;
  perf_counter_two_event_select dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(aa), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_bresp(br),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ra), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rv), .s_axi_rready(1'b1), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .core_events(ev_in), .second_event_counter(cnt));
  core_event_model src (.aclk(aclk), .next_ev(ev), .core_events(ev_in));
  initial forever #5 aclk = ~aclk;
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    aa <= a;
    wd <= d;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv);
    cmp("bresp", {30'h0, er}, {30'h0, br});
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] x, input logic [1:0] er);
    ra <= a;
    arv <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    cmp("rdata", x, rd);
    cmp("rresp", {30'h0, er}, {30'h0, rr});
  endtask : axi_rd
  // Selects a code, clears the counter, raises the events for four cycles, reads the total.
  task automatic run(input logic [6:0] c, input perf_counter_two_pkg::core_event_t e,
                     input logic [31:0] x);
    axi_wr(4'h0, {25'h0, c}, 4'hf, OK);
    axi_wr(4'h8, 32'h0, 4'hf, OK);
    ev <= e;
    repeat (4) @(posedge aclk);
    ev <= '0;
    repeat (3) @(posedge aclk);
    axi_rd(4'h8, x, OK);
    cmp("counter", x, cnt);
  endtask : run
  task automatic t_regs;
    axi_rd(4'h0, 32'h0, OK);
    axi_rd(4'h4, 32'h0, OK);
    axi_rd(4'h8, 32'h0, OK);
    axi_wr(4'h8, 32'h1122_3344, 4'h3, OK);
    axi_rd(4'h8, 32'h0000_3344, OK);
    axi_wr(4'hc, 32'hffff_ffff, 4'hf, perf_counter_two_pkg::RESP_SLVERR);
    axi_rd(4'h1, 32'h0, perf_counter_two_pkg::RESP_SLVERR);
  endtask : t_regs
  task automatic t_events;
    perf_counter_two_pkg::core_event_t e;
    e = '0;
    e.lsu_done_cnt = 2'h3;
    run(7'h00, e, 32'h0);
    run(7'h19, e, 32'hc);
    e = '0;
    e.load_done = 1'b1;
    run(7'h1a, e, 32'h4);
    e.load_excluded_op = 1'b1;
    run(7'h1a, e, 32'h0);
    e = '0;
    e.string_store_done = 1'b1;
    run(7'h1b, e, 32'h4);
    e = '0;
    e.move_from_spr_done = 1'b1;
    e.move_from_spr_vector_status = 1'b1;
    run(7'h1e, e, 32'h0);
    e = '0;
    e.isync_done = 1'b1;
    run(7'h1f, e, 32'h4);
    e = '0;
    e.complete_cnt = 2'h2;
    run(7'h21, e, 32'h0);
    e.dispatch_cnt = 2'h2;
    run(7'h22, e, 32'h4);
    e = '0;
    e.touch_cancel_cnt = 3'h7;
    run(7'h2b, e, 32'h10);
    e = '0;
    e.user_privilege_bit = 1'b1;
    run(7'h3d, e, 32'h2);
    e.itrans_miss = 1'b1;
    run(7'h23, e, 32'h4);
    e.icache_miss_pending = 1'b1;
    run(7'h24, e, 32'h4);
    e.dload_miss = 1'b1;
    e.dload_miss_touch = 1'b1;
    run(7'h25, e, 32'h0);
    e.dtouch_miss_reload = 1'b1;
    run(7'h26, e, 32'h4);
    e.dstore_miss = 1'b1;
    run(7'h27, e, 32'h4);
    e.dtouch_miss_pending = 1'b1;
    run(7'h28, e, 32'h4);
    e.dcache_busy = 1'b1;
    run(7'h29, e, 32'h4);
    e.touch_fetch = 1'b1;
    run(7'h2e, e, 32'h4);
    e.tlb_inval_snoop = 1'b1;
    run(7'h2f, e, 32'h4);
    e.dreload = 1'b1;
    e.dreload_all_locked = 1'b1;
    run(7'h31, e, 32'h0);
    e.castout = 1'b1;
    run(7'h32, e, 32'h4);
    e.not_taken_cnt = 2'h2;
    run(7'h36, e, 32'h8);
    e.float_store_single_done = 1'b1;
    run(7'h3e, e, 32'h4);
  endtask : t_events
  task automatic t_threshold;
    perf_counter_two_pkg::core_event_t e;
    e = '0;
    axi_wr(4'h4, 32'h5, 4'hf, OK);
    axi_rd(4'h4, 32'h5, OK);
    e.cq_valid_entries = 6'h5;
    run(7'h20, e, 32'h4);
    e.cq_valid_entries = 6'h4;
    run(7'h20, e, 32'h0);
  endtask : t_threshold
  task automatic end_of_test;
    $display("mismatches %0d comparisons %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_events();
    t_threshold();
    end_of_test();
  end
  initial begin
    repeat (5000) @(posedge aclk);
    error_cnt++;
    end_of_test();
  end
endmodule : tb
`default_nettype wire
